// ===== shared/bwua_defines.svh
// Behaviour
// [RL1] prefetch base high register gives bits 63:32 of the window floor
// [RL2] prefetch limit high register gives bits 63:32 of the window ceiling
// [RL3] prefetch base high sits at 28h, fully read/write, resets to zero
// [RL4] prefetch limit high sits at 2Ch, fully read/write, resets to zero
// [RL5] memory addresses compared with 64-bit prefetch window to decide forwarding
// [RL6] io base high gives address bits 31:20 of io floor, low 20 bits zero
// [RL7] io limit high gives bits 31:20 of io ceiling, low 20 bits ones
// [RL8] io base high is 16-bit read/write at 30h, resets to zero
// [RL9] io limit high is 16-bit read/write at 32h, resets to zero
// [RL10] io addresses compared with extended io window to decide forwarding
// [RL11] low prefetch base field gives bits 31:20 of floor, low bits zero
// [RL12] low prefetch limit field gives bits 31:20 of ceiling, low bits ones
// [RL13] low four bits of low prefetch registers read-only, flag 64-bit support
// [RL14] inside a window means floor <= address <= ceiling, both inclusive
`ifndef BWUA_DEFINES_SVH
`define BWUA_DEFINES_SVH

// ==========================================================
// configuration offsets (byte addresses)
`define BWUA_OFF_PREF_LOW        8'h24
`define BWUA_OFF_PREF_BASE_HIGH  8'h28
`define BWUA_OFF_PREF_LIMIT_HIGH 8'h2C
`define BWUA_OFF_IO_BASE_HIGH    8'h30
`define BWUA_OFF_IO_LIMIT_HIGH   8'h32

// ==========================================================
// field positions
`define BWUA_LOW_FIELD_LSB       4
`define BWUA_LIMIT_HALF_LSB      16
`define BWUA_WIN_GRAIN           20

// ==========================================================
// reset and fixed values
`define BWUA_RST_WORD            32'h0000_0000
`define BWUA_RST_HALF            16'h0000
`define BWUA_RST_FIELD           12'h000
`define BWUA_WIDE_ADDRESS_FLAG   4'h1
`define BWUA_FLOOR_FILL          20'h00000
`define BWUA_CEIL_FILL           20'hFFFFF
`define BWUA_UPPER_ZERO          32'h0000_0000

`endif

// ===== shared/bwua_pkg.sv
`default_nettype none
`include "bwua_defines.svh"

package bwua_pkg;

  // ==========================================================
  // transaction kind
  typedef enum logic {
    BWUA_KIND_MEM = 1'b0,
    BWUA_KIND_IO  = 1'b1
  } bwua_kind_t;

  // ==========================================================
  // whole state of the register bank
  typedef struct packed {
    logic [11:0] prefetch_window_floor_low;
    logic [11:0] prefetch_window_ceiling_low;
    logic [31:0] prefetch_window_base_high_reg;
    logic [31:0] prefetch_window_limit_high_reg;
    logic [15:0] io_window_base_high_reg;
    logic [15:0] io_window_limit_high_reg;
    logic [31:0] rd_data;
    logic        ack;
    logic        fwd_valid;
    logic        fwd_hit;
    logic        fwd_is_io;
  } bwua_state_t;

  // ==========================================================
  // helpers
  function automatic logic bwua_in_window(input logic [63:0] addr,
                                          input logic [63:0] floor,
                                          input logic [63:0] ceiling);
    bwua_in_window = (addr >= floor) && (addr <= ceiling); // [RL14]
  endfunction : bwua_in_window

  function automatic logic [31:0] bwua_merge(input logic [31:0] old_word,
                                             input logic [31:0] new_word,
                                             input logic [3:0]  be);
    logic [31:0] res;
    res = old_word;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = new_word[8*i +: 8];
      end
    end
    bwua_merge = res;
  endfunction : bwua_merge

endpackage : bwua_pkg

`default_nettype wire

// ===== rtl/bwua_fwd_decide.sv
`default_nettype none
`include "bwua_defines.svh"

module bwua_fwd_decide
  import bwua_pkg::*;
#(
  parameter int AW = 64
) (
  // transaction
  input  wire logic [AW-1:0] addr_in,
  input  wire logic          is_io_in,
  // assembled windows
  input  wire logic [AW-1:0] mem_floor_in,
  input  wire logic [AW-1:0] mem_ceiling_in,
  input  wire logic [AW-1:0] io_floor_in,
  input  wire logic [AW-1:0] io_ceiling_in,
  // decision
  output logic               hit_out
);

  logic [AW-1:0] io_addr;
  logic          mem_hit;
  logic          io_hit;

  // io space is 32 bits wide; upper half of the bus is ignored for io
  assign io_addr = {`BWUA_UPPER_ZERO, addr_in[31:0]};
  assign mem_hit = bwua_in_window(addr_in, mem_floor_in, mem_ceiling_in); // [RL5] [RL14]
  assign io_hit  = bwua_in_window(io_addr, io_floor_in, io_ceiling_in);   // [RL10]
  assign hit_out = (is_io_in == BWUA_KIND_IO) ? io_hit : mem_hit;

endmodule : bwua_fwd_decide

`default_nettype wire

// ===== rtl/bwua_regs.sv
`default_nettype none
`include "bwua_defines.svh"

module bwua_regs
  import bwua_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  // configuration access
  input  wire logic        cfg_wr_in,
  input  wire logic        cfg_rd_in,
  input  wire logic [7:0]  cfg_addr_in,
  input  wire logic [3:0]  cfg_be_in,
  input  wire logic [31:0] cfg_wdata_in,
  output logic      [31:0] cfg_rdata_out,
  output logic             cfg_ack_out,
  // transaction to classify
  input  wire logic        txn_valid_in,
  input  wire logic        txn_is_io_in,
  input  wire logic [63:0] txn_addr_in,
  // forwarding decision
  output logic             fwd_valid_out,
  output logic             fwd_hit_out,
  output logic             fwd_is_io_out
);

  // ==========================================================
  // dword indices
  localparam logic [5:0] IDX_PREF_LOW   = 6'(`BWUA_OFF_PREF_LOW >> 2);
  localparam logic [5:0] IDX_PREF_BASE  = 6'(`BWUA_OFF_PREF_BASE_HIGH >> 2);
  localparam logic [5:0] IDX_PREF_LIMIT = 6'(`BWUA_OFF_PREF_LIMIT_HIGH >> 2);
  localparam logic [5:0] IDX_IO         = 6'(`BWUA_OFF_IO_BASE_HIGH >> 2);
  localparam int         HI             = `BWUA_LIMIT_HALF_LSB;
  localparam int         FL             = `BWUA_LOW_FIELD_LSB;

  bwua_state_t st;
  bwua_state_t next_st;

  logic [5:0]  idx;
  logic [31:0] pref_low_word;
  logic [31:0] io_word;
  logic [31:0] merged;
  logic [63:0] mem_floor;
  logic [63:0] mem_ceiling;
  logic [63:0] io_floor;
  logic [63:0] io_ceiling;
  logic        hit;

  assign idx = cfg_addr_in[7:2];

  // ==========================================================
  // read views; wide address flag is hardwired in both halves
  assign pref_low_word = {st.prefetch_window_ceiling_low, `BWUA_WIDE_ADDRESS_FLAG,
                          st.prefetch_window_floor_low, `BWUA_WIDE_ADDRESS_FLAG}; // [RL13]
  assign io_word       = {st.io_window_limit_high_reg, st.io_window_base_high_reg};

  // ==========================================================
  // window assembly
  assign mem_floor   = {st.prefetch_window_base_high_reg,
                        st.prefetch_window_floor_low, `BWUA_FLOOR_FILL}; // [RL1] [RL11]
  assign mem_ceiling = {st.prefetch_window_limit_high_reg,
                        st.prefetch_window_ceiling_low, `BWUA_CEIL_FILL}; // [RL2] [RL12]
  // only the low twelve bits of each io half land on address bits 31:20
  assign io_floor    = {`BWUA_UPPER_ZERO, st.io_window_base_high_reg[11:0],
                        `BWUA_FLOOR_FILL}; // [RL6]
  assign io_ceiling  = {`BWUA_UPPER_ZERO, st.io_window_limit_high_reg[11:0],
                        `BWUA_CEIL_FILL}; // [RL7]

  bwua_fwd_decide #(
    .AW (64)
  ) u_decide (
    .addr_in        (txn_addr_in),
    .is_io_in       (txn_is_io_in),
    .mem_floor_in   (mem_floor),
    .mem_ceiling_in (mem_ceiling),
    .io_floor_in    (io_floor),
    .io_ceiling_in  (io_ceiling),
    .hit_out        (hit)
  );

  // ==========================================================
  // next state
  always_comb begin
    next_st  = st;
    merged   = `BWUA_RST_WORD;
    next_st.ack       = cfg_rd_in | cfg_wr_in;
    next_st.fwd_valid = txn_valid_in;
    // decision held between transactions so the downstream side can sample late
    if (txn_valid_in) begin
      next_st.fwd_hit   = hit; // [RL5] [RL10]
      next_st.fwd_is_io = txn_is_io_in;
    end
    if (cfg_rd_in) begin
      case (idx)
        IDX_PREF_LOW:   next_st.rd_data = pref_low_word;
        IDX_PREF_BASE:  next_st.rd_data = st.prefetch_window_base_high_reg;
        IDX_PREF_LIMIT: next_st.rd_data = st.prefetch_window_limit_high_reg;
        IDX_IO:         next_st.rd_data = io_word;
        default:        next_st.rd_data = `BWUA_RST_WORD;
      endcase
    end
    if (cfg_wr_in) begin
      case (idx)
        IDX_PREF_LOW: begin
          merged = bwua_merge(pref_low_word, cfg_wdata_in, cfg_be_in);
          next_st.prefetch_window_floor_low   = merged[FL +: 12];      // [RL11]
          next_st.prefetch_window_ceiling_low = merged[HI + FL +: 12]; // [RL12]
        end
        IDX_PREF_BASE: begin
          next_st.prefetch_window_base_high_reg =
            bwua_merge(st.prefetch_window_base_high_reg, cfg_wdata_in, cfg_be_in); // [RL3]
        end
        IDX_PREF_LIMIT: begin
          next_st.prefetch_window_limit_high_reg =
            bwua_merge(st.prefetch_window_limit_high_reg, cfg_wdata_in, cfg_be_in); // [RL4]
        end
        IDX_IO: begin
          merged = bwua_merge(io_word, cfg_wdata_in, cfg_be_in);
          next_st.io_window_base_high_reg  = merged[HI-1:0]; // [RL8]
          next_st.io_window_limit_high_reg = merged[31:HI];  // [RL9]
        end
        default: begin
          merged = `BWUA_RST_WORD;
        end
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st.prefetch_window_floor_low      <= `BWUA_RST_FIELD;
      st.prefetch_window_ceiling_low    <= `BWUA_RST_FIELD;
      st.prefetch_window_base_high_reg  <= `BWUA_RST_WORD; // [RL3]
      st.prefetch_window_limit_high_reg <= `BWUA_RST_WORD; // [RL4]
      st.io_window_base_high_reg        <= `BWUA_RST_HALF; // [RL8]
      st.io_window_limit_high_reg       <= `BWUA_RST_HALF; // [RL9]
      st.rd_data                        <= `BWUA_RST_WORD;
      st.ack                            <= 1'b0;
      st.fwd_valid                      <= 1'b0;
      st.fwd_hit                        <= 1'b0;
      st.fwd_is_io                      <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign cfg_rdata_out = st.rd_data;
  assign cfg_ack_out   = st.ack;
  assign fwd_valid_out = st.fwd_valid;
  assign fwd_hit_out   = st.fwd_hit;
  assign fwd_is_io_out = st.fwd_is_io;

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  base_high_write_a : assert property ( // [RL3]
    (cfg_wr_in && idx == IDX_PREF_BASE && cfg_be_in == 4'hF)
    |=> st.prefetch_window_base_high_reg == $past(cfg_wdata_in))
    else $error("prefetch base high did not take written word");

  limit_high_write_a : assert property ( // [RL4]
    (cfg_wr_in && idx == IDX_PREF_LIMIT && cfg_be_in == 4'hF)
    |=> st.prefetch_window_limit_high_reg == $past(cfg_wdata_in))
    else $error("prefetch limit high did not take written word");

  io_base_write_a : assert property ( // [RL8]
    (cfg_wr_in && idx == IDX_IO && cfg_be_in[1:0] == 2'h3)
    |=> st.io_window_base_high_reg == $past(cfg_wdata_in[15:0]))
    else $error("io base high did not take written half");

  io_limit_write_a : assert property ( // [RL9]
    (cfg_wr_in && idx == IDX_IO && cfg_be_in[3:2] == 2'h3)
    |=> cfg_ack_out && st.io_window_limit_high_reg == $past(cfg_wdata_in[31:16]))
    else $error("io limit high did not take written half");

  reset_clear_a : assert property (@(posedge core_clk_in) disable iff (1'b0) // [RL3]
    rst_in |=> (st.prefetch_window_base_high_reg == 32'h0000_0000 &&
                st.prefetch_window_limit_high_reg == 32'h0000_0000 &&
                st.io_window_base_high_reg == 16'h0000 &&
                st.io_window_limit_high_reg == 16'h0000 && !cfg_ack_out))
    else $error("window registers not cleared by reset");

  wide_flag_read_a : assert property ( // [RL13]
    (cfg_rd_in && !cfg_wr_in && idx == IDX_PREF_LOW)
    |=> cfg_ack_out && cfg_rdata_out[3:0] == 4'h1 && cfg_rdata_out[19:16] == 4'h1)
    else $error("wide address flag not read back");

  mem_forward_a : assert property ( // [RL1] [RL2] [RL5] [RL14]
    (txn_valid_in && !txn_is_io_in && !cfg_wr_in)
    |=> fwd_valid_out && !fwd_is_io_out &&
        fwd_hit_out == (($past(txn_addr_in) >= {st.prefetch_window_base_high_reg,
                           st.prefetch_window_floor_low, 20'h00000}) &&
                        ($past(txn_addr_in) <= {st.prefetch_window_limit_high_reg,
                           st.prefetch_window_ceiling_low, 20'hFFFFF})))
    else $error("memory forwarding decision wrong");

  io_forward_a : assert property ( // [RL6] [RL7] [RL10]
    (txn_valid_in && txn_is_io_in && !cfg_wr_in)
    |=> fwd_valid_out && fwd_is_io_out &&
        fwd_hit_out == (($past(txn_addr_in[31:20]) >= st.io_window_base_high_reg[11:0]) &&
                        ($past(txn_addr_in[31:20]) <= st.io_window_limit_high_reg[11:0])))
    else $error("io forwarding decision wrong");

  hit_hold_a : assert property ( // [RL5] [RL10]
    !txn_valid_in |=> $stable(fwd_hit_out) && !fwd_valid_out)
    else $error("forward decision changed without a transaction");

  // ==========================================================
  // access, hold, forward kind and reset checks
  ack_after_access_a : assert property ( // [RL3] [RL4] [RL8] [RL9]
    (cfg_rd_in || cfg_wr_in)
    |=> cfg_ack_out)
    else $error("access not acknowledged one cycle later");

  ack_only_access_a : assert property ( // [RL3] [RL4] [RL8] [RL9]
    !(cfg_rd_in || cfg_wr_in)
    |=> !cfg_ack_out)
    else $error("acknowledge without an access");

  // no write in the read cycle, so the register still holds what was read
  base_high_read_a : assert property ( // [RL3]
    (cfg_rd_in && !cfg_wr_in && idx == IDX_PREF_BASE)
    |=> cfg_rdata_out == st.prefetch_window_base_high_reg)
    else $error("prefetch base high read back wrong");

  limit_high_read_a : assert property ( // [RL4]
    (cfg_rd_in && !cfg_wr_in && idx == IDX_PREF_LIMIT)
    |=> cfg_rdata_out == st.prefetch_window_limit_high_reg)
    else $error("prefetch limit high read back wrong");

  io_pair_read_a : assert property ( // [RL8] [RL9]
    (cfg_rd_in && !cfg_wr_in && idx == IDX_IO)
    |=> cfg_rdata_out == {st.io_window_limit_high_reg, st.io_window_base_high_reg})
    else $error("io pair read back wrong");

  unmapped_read_a : assert property (
    (cfg_rd_in && !cfg_wr_in && (idx < IDX_PREF_LOW || idx > IDX_IO))
    |=> cfg_rdata_out == 32'h0000_0000)
    else $error("unmapped dword did not read zero");

  base_high_keep_a : assert property ( // [RL3]
    !(cfg_wr_in && idx == IDX_PREF_BASE)
    |=> $stable(st.prefetch_window_base_high_reg))
    else $error("prefetch base high changed without a write");

  limit_high_keep_a : assert property ( // [RL4]
    !(cfg_wr_in && idx == IDX_PREF_LIMIT)
    |=> $stable(st.prefetch_window_limit_high_reg))
    else $error("prefetch limit high changed without a write");

  io_pair_keep_a : assert property ( // [RL8] [RL9]
    !(cfg_wr_in && idx == IDX_IO)
    |=> $stable(st.io_window_base_high_reg) &&
        $stable(st.io_window_limit_high_reg))
    else $error("io pair changed without a write");

  low_fields_keep_a : assert property ( // [RL11] [RL12]
    !(cfg_wr_in && idx == IDX_PREF_LOW)
    |=> $stable(st.prefetch_window_floor_low) &&
        $stable(st.prefetch_window_ceiling_low))
    else $error("low prefetch fields changed without a write");

  low_fields_write_a : assert property ( // [RL11] [RL12]
    (cfg_wr_in && idx == IDX_PREF_LOW && cfg_be_in == 4'hF)
    |=> st.prefetch_window_floor_low == $past(cfg_wdata_in[15:4]) &&
        st.prefetch_window_ceiling_low == $past(cfg_wdata_in[31:20]))
    else $error("low prefetch fields did not take written word");

  base_lane_keep_a : assert property ( // [RL3]
    (cfg_wr_in && idx == IDX_PREF_BASE && !cfg_be_in[3])
    |=> st.prefetch_window_base_high_reg[31:24] ==
        $past(st.prefetch_window_base_high_reg[31:24]))
    else $error("prefetch base high lane written without enable");

  limit_lane_keep_a : assert property ( // [RL4]
    (cfg_wr_in && idx == IDX_PREF_LIMIT && !cfg_be_in[0])
    |=> st.prefetch_window_limit_high_reg[7:0] ==
        $past(st.prefetch_window_limit_high_reg[7:0]))
    else $error("prefetch limit high lane written without enable");

  io_lane_keep_a : assert property ( // [RL9]
    (cfg_wr_in && idx == IDX_IO && cfg_be_in[3:2] == 2'b00)
    |=> $stable(st.io_window_limit_high_reg))
    else $error("io limit high written without enable");

  fwd_kind_a : assert property ( // [RL5] [RL10]
    txn_valid_in
    |=> fwd_valid_out && fwd_is_io_out == $past(txn_is_io_in))
    else $error("forward decision missing or of wrong kind");

  kind_hold_a : assert property ( // [RL10]
    !txn_valid_in
    |=> $stable(fwd_is_io_out))
    else $error("forward kind changed without a transaction");

  low_reset_a : assert property (@(posedge core_clk_in) disable iff (1'b0) // [RL11] [RL12] [RL13]
    rst_in |=> (st.prefetch_window_floor_low == 12'h000 &&
                st.prefetch_window_ceiling_low == 12'h000 &&
                pref_low_word == 32'h0001_0001 &&
                !fwd_valid_out && !fwd_hit_out))
    else $error("low prefetch fields not cleared by reset");

endmodule : bwua_regs

`default_nettype wire

// ===== tb/bwua_host.sv
`default_nettype none
// ==========================================
// upstream host: config and transaction requests
module bwua_host (
  // clock
  input  wire logic        core_clk_in,
  // config requests
  output logic             cfg_wr_out,
  output logic             cfg_rd_out,
  output logic [7:0]       cfg_addr_out,
  output logic [3:0]       cfg_be_out,
  output logic [31:0]      cfg_wdata_out,
  // transactions to classify
  output logic             txn_valid_out,
  output logic             txn_is_io_out,
  output logic [63:0]      txn_addr_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {cfg_wr_out, cfg_rd_out, txn_valid_out, txn_is_io_out} = 4'h0;
    {cfg_addr_out, cfg_be_out, cfg_wdata_out, txn_addr_out} = '0;
  end

  // idle address, byte enable and data lines show the inverse so a stale value never reads as valid
  task automatic drive(input logic wr, rd, tv, io, input logic [7:0] a,
                       input logic [3:0] be, input logic [31:0] d,
                       input logic [63:0] ta);
    @(negedge core_clk_in);
    cfg_wr_out    = wr;
    cfg_rd_out    = rd;
    txn_valid_out = tv;
    txn_is_io_out = io;
    cfg_addr_out  = (wr | rd) ? a : ~cfg_addr_out;
    cfg_be_out    = wr ? be : ~cfg_be_out;
    cfg_wdata_out = wr ? d : ~cfg_wdata_out;
    txn_addr_out  = tv ? ta : ~txn_addr_out;
  endtask : drive
endmodule : bwua_host
`default_nettype wire

// ===== tb/bwua_regs_tb.sv
`default_nettype none
module bwua_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst;
  logic cfg_wr, cfg_rd, txn_valid, txn_is_io, cfg_ack, fwd_valid, fwd_hit, fwd_is_io;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, r, b;
  logic [63:0] txn_addr, f, c;
  logic [31:0] sh [4];
  logic [32:0] cq [$];
  logic [32:0] note;
  logic [1:0] fq [$];
  logic [7:0] offs [5] = '{8'h24, 8'h28, 8'h2C, 8'h30, 8'h34};
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;

  bwua_host host (.core_clk_in(core_clk), .cfg_wr_out(cfg_wr), .cfg_rd_out(cfg_rd),
    .cfg_addr_out(cfg_addr), .cfg_be_out(cfg_be), .cfg_wdata_out(cfg_wdata),
    .txn_valid_out(txn_valid), .txn_is_io_out(txn_is_io), .txn_addr_out(txn_addr));
  bwua_regs uut (.core_clk_in(core_clk), .rst_in(rst), .cfg_wr_in(cfg_wr), .cfg_rd_in(cfg_rd),
    .cfg_addr_in(cfg_addr), .cfg_be_in(cfg_be), .cfg_wdata_in(cfg_wdata),
    .cfg_rdata_out(cfg_rdata), .cfg_ack_out(cfg_ack), .txn_valid_in(txn_valid),
    .txn_is_io_in(txn_is_io), .txn_addr_in(txn_addr), .fwd_valid_out(fwd_valid),
    .fwd_hit_out(fwd_hit), .fwd_is_io_out(fwd_is_io));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // ==========================================
  // comparison, verdict, shadow model
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  function automatic logic hit(input logic io, input logic [63:0] x);
    logic [63:0] lo, hi;
    lo = io ? {32'h0, sh[3][11:0], 20'h00000} : {sh[1], sh[0][15:4], 20'h00000};
    hi = io ? {32'h0, sh[3][27:16], 20'hFFFFF} : {sh[2], sh[0][31:20], 20'hFFFFF};
    if (io) x = {32'h0, x[31:0]};
    return (x >= lo) && (x <= hi);
  endfunction : hit

  task automatic clear_shadow();
    sh = '{32'h0001_0001, 32'h0, 32'h0, 32'h0};
  endtask : clear_shadow

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    logic [5:0] k;
    k = a[7:2] - 6'h09;
    host.drive(1'b1, 1'b0, 1'b0, 1'b0, a, be, d, 64'h0);
    cq.push_back({1'b0, 32'h0});
    if (k < 6'h04) begin
      for (int i = 0; i < 4; i++) if (be[i]) sh[k][8*i +: 8] = d[8*i +: 8];
      if (k == 6'h00) sh[0] = (sh[0] & 32'hFFF0_FFF0) | 32'h0001_0001;
    end
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic [5:0] k;
    k = a[7:2] - 6'h09;
    host.drive(1'b0, 1'b1, 1'b0, 1'b0, a, 4'h0, 32'h0, 64'h0);
    cq.push_back({1'b1, (k < 6'h04) ? sh[k] : 32'h0});
  endtask : rd

  task automatic tx(input logic io, input logic [63:0] x);
    host.drive(1'b0, 1'b0, 1'b1, io, 8'h00, 4'h0, 32'h0, x);
    fq.push_back({io, hit(io, x)});
  endtask : tx

  task automatic idle(input int n);
    repeat (n) host.drive(1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 4'h0, 32'h0, 64'h0);
  endtask : idle

  // ==========================================
  // output watcher: oldest note against each answer
  always @(negedge core_clk) begin
    if (cfg_ack === 1'b1) begin
      if (cq.size() == 0) chk(64'h1, 64'h0);
      else if (cq[0][32]) begin
        note = cq.pop_front();
        chk({32'h0, cfg_rdata}, {32'h0, note[31:0]});
      end
      else void'(cq.pop_front());
    end
    if (fwd_valid === 1'b1) begin
      if (fq.size() == 0) chk(64'h1, 64'h0);
      else chk({62'h0, fwd_is_io, fwd_hit}, {62'h0, fq.pop_front()});
    end
  end

  // hang guard: whole run needs well under 1000 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      results();
    end
  end

  // ==========================================
  // main sequence
  initial begin
    rst = 1'b1;
    r = 32'h0000_0249;
    clear_shadow();
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    foreach (offs[i]) rd(offs[i]);
    foreach (offs[i]) begin
      wr(offs[i], 4'hF, 32'hFFFF_FFFF);
      rd(offs[i]);
    end
    // partial byte enables and ignored low address bits
    repeat (40) begin
      r = lfsr(r);
      wr(offs[r[7:0] % 5] | {6'h0, r[9:8]}, r[13:10], lfsr(r));
      rd(offs[r[7:0] % 5]);
    end
    r = lfsr(r);
    b = r;
    wr(8'h28, 4'hF, b);
    wr(8'h2C, 4'hF, b);
    wr(8'h24, 4'hF, 32'h4560_1230);
    wr(8'h30, 4'hF, 32'hF456_A123);
    // edges of both windows, io upper half must be ignored
    for (int io = 0; io < 2; io++) begin
      f = {io ? ~b : b, 32'h1230_0000};
      c = {io ? ~b : b, 32'h456F_FFFF};
      for (int j = 0; j < 2; j++) begin
        tx(io[0], f - 64'h1 + 64'(j));
        tx(io[0], c + 64'(j));
      end
    end
    tx(1'b0, {b + 32'h1, 32'h2000_0000});
    repeat (40) begin
      r = lfsr(r);
      tx(r[0], {r[1] ? b : r, r[2] ? r : (r | 32'h1000_0000)});
    end
    idle(3);
    rst = 1'b1;
    clear_shadow();
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    foreach (offs[i]) rd(offs[i]);
    idle(4);
    if (cq.size() != 0 || fq.size() != 0) chk(64'h1, 64'h0);
    results();
  end
endmodule : bwua_regs_tb
`default_nettype wire
